// file: fsupc_pkg.sv
package fsupc_pkg;

  // ==========================================================================
  // object indices
  localparam logic [15:0] IDX_PROG_CTRL   = 16'h2300;
  localparam logic [15:0] IDX_PROG_STATE  = 16'h2301;
  localparam logic [15:0] IDX_PROG_FAULT  = 16'h2302;
  localparam logic [15:0] IDX_BUS_STATUS  = 16'h2103;
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_CAP_MASK    = 8'h01;
  localparam logic [7:0]  SUB_ACTIVE      = 8'h02;

  // ==========================================================================
  // interface bit layout
  localparam int BIT_USB       = 0;
  localparam int BIT_RS485     = 1;
  localparam int BIT_RS232     = 2;
  localparam int BIT_CAN       = 3;
  localparam int BIT_ETH       = 4;
  localparam int BIT_IND_ETH   = 5;
  localparam int BIT_SPI       = 6;
  localparam int BIT_SER_PROTO = 16;
  localparam int BIT_TCP_PROTO = 17;
  localparam int BIT_IND_IP    = 18;
  localparam logic [31:0] IFACE_USED_MASK = 32'h0007_007F;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  RST_ENTRY_COUNT = 8'h02;
  localparam logic [31:0] RST_CAP_MASK    = 32'h0000_0000;
  localparam logic [31:0] RST_ACTIVE      = 32'h0000_0040;
  localparam logic [31:0] RST_CTRL        = 32'h0000_0000;

  // ==========================================================================
  // control and status fields
  localparam int CTRL_ON_BIT    = 0;
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_ERR_BIT   = 2;

  // ==========================================================================
  // fault codes
  localparam logic [31:0] FC_NONE          = 32'h0000_0000;
  localparam logic [31:0] FC_EXEC_FIRST    = 32'h0000_0001;
  localparam logic [31:0] FC_EXEC_LAST     = 32'h0000_0007;
  localparam logic [31:0] FC_BAD_FILE      = 32'h0000_0100;
  localparam logic [7:0]  FC_MAP_PREFIX    = 8'h10;
  localparam logic [31:0] FC_NO_OBJECT     = 32'h0000_1000;
  localparam logic [31:0] FC_WRITE_PROT    = 32'h0000_1001;
  localparam logic [31:0] FC_FS_INTERNAL   = 32'h0000_1002;
  localparam logic [31:0] FC_LOAD_FIRST    = 32'h0001_0002;
  localparam logic [31:0] FC_LOAD_LAST     = 32'h0001_0010;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STARTUP_MAX_MS   = 200;
  localparam int STARTUP_CYCLES   = STARTUP_MAX_MS * 1000000 / CLK_PERIOD_NS;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } fsupc_req_s;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } fsupc_rsp_s;

  // engine report: fault class and detail for the program's termination
  typedef enum logic [2:0] {
    FK_EXEC    = 3'h0,
    FK_FILE    = 3'h1,
    FK_MAP     = 3'h2,
    FK_ACCESS  = 3'h3,
    FK_LOAD    = 3'h4
  } fsupc_fault_kind_e;

  typedef struct packed {
    logic              valid;
    fsupc_fault_kind_e kind;
    logic [15:0]       index;
    logic [7:0]        subindex;
    logic [7:0]        code;
  } fsupc_fault_s;

  typedef enum logic [3:0] {
    PS_STOPPED = 4'b0001,
    PS_LOADING = 4'b0010,
    PS_RUNNING = 4'b0100,
    PS_FAULTED = 4'b1000
  } fsupc_state_e;

endpackage

// file: fsupc_fault_enc.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// turns an engine fault report into the 32-bit code software reads
module fsupc_fault_enc (
  input  wire fsupc_pkg::fsupc_fault_s fault,
  output logic [31:0]                  code
);
  wire [31:0] exec_code   = {24'h0, fault.code};
  wire [31:0] map_code    = {fsupc_pkg::FC_MAP_PREFIX, fault.index, fault.subindex};
  wire [31:0] access_code = fsupc_pkg::FC_NO_OBJECT | {30'h0, fault.code[1:0]};
  wire [31:0] load_code   = fsupc_pkg::FC_LOAD_FIRST + {24'h0, fault.code};

  always_comb begin
    case (fault.kind)
      fsupc_pkg::FK_EXEC:   code = exec_code;
      fsupc_pkg::FK_FILE:   code = fsupc_pkg::FC_BAD_FILE;
      fsupc_pkg::FK_MAP:    code = map_code;
      fsupc_pkg::FK_ACCESS: code = access_code;
      fsupc_pkg::FK_LOAD:   code = load_code;
      default:              code = fsupc_pkg::FC_FS_INTERNAL;
    endcase
  end
endmodule
`default_nettype wire

// file: fsupc_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - capability mask bit is 1 when that interface or protocol may be disabled.
// - active word bit is 1 while that interface or protocol is active.
// - bits 0-6 physical interfaces, bits 16-18 protocols, others read zero.
// - status array: 8-bit count 02h, two read-only 32-bit entries, unmappable.
// - after reset the mask reads zero and the active word reads 40h.
// - control bit 0 switches the program on or off; register RW, resets zero.
// - rising edge of control bit 0 reloads program and clears variables first.
// - status running flag reads 1 while executing, 0 when stopped; resets zero.
// - status error flag set when the program ends on a fault.
// - fault code 0 none, 1-7 execution faults, 100h bad program file.
// - unmappable object reported as 10h, index, subindex.
// - object access faults 1000h, 1001h, 1002h.
// - load failures reported as 10002h through 10010h.
module fsupc_regs (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire fsupc_pkg::fsupc_req_s   req,
  output fsupc_pkg::fsupc_rsp_s        rsp,
  input  wire logic [31:0]             cap_mask_in,
  input  wire logic [31:0]             active_in,
  output logic                         prog_reload,
  output logic                         prog_enable,
  input  wire logic                    prog_loaded,
  input  wire logic                    prog_stopped,
  input  wire fsupc_pkg::fsupc_fault_s prog_fault
);

  // ==========================================================================
  // decode
  wire is_ctrl   = req.index == fsupc_pkg::IDX_PROG_CTRL  && req.subindex == 8'h00;
  wire is_state  = req.index == fsupc_pkg::IDX_PROG_STATE && req.subindex == 8'h00;
  wire is_fault  = req.index == fsupc_pkg::IDX_PROG_FAULT && req.subindex == 8'h00;
  wire is_bus    = req.index == fsupc_pkg::IDX_BUS_STATUS;
  wire is_count  = is_bus && req.subindex == fsupc_pkg::SUB_COUNT;
  wire is_cap    = is_bus && req.subindex == fsupc_pkg::SUB_CAP_MASK;
  wire is_active = is_bus && req.subindex == fsupc_pkg::SUB_ACTIVE;
  wire hit       = is_ctrl | is_state | is_fault | is_count | is_cap | is_active;
  wire wr_ok     = req.wr && is_ctrl;
  wire acc       = req.rd | req.wr;

  // ==========================================================================
  // interface status words, held in flops so reads come from registers
  logic [31:0] cap_q;
  logic [31:0] active_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_q    <= fsupc_pkg::RST_CAP_MASK;
      active_q <= fsupc_pkg::RST_ACTIVE;
    end else if (clk_en) begin
      cap_q    <= cap_mask_in & fsupc_pkg::IFACE_USED_MASK;
      active_q <= active_in & fsupc_pkg::IFACE_USED_MASK;
    end
  end

  // ==========================================================================
  // control register
  logic [31:0] ctrl_q;
  logic        on_prev_q;
  wire  [31:0] ctrl_d = wr_ok ? req.wdata : ctrl_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q    <= fsupc_pkg::RST_CTRL;
      on_prev_q <= 1'b0;
    end else if (clk_en) begin
      ctrl_q    <= ctrl_d;
      on_prev_q <= ctrl_q[fsupc_pkg::CTRL_ON_BIT];
    end
  end
  wire on_now  = ctrl_q[fsupc_pkg::CTRL_ON_BIT];
  wire on_rise = on_now && !on_prev_q;

  // ==========================================================================
  // program state machine
  fsupc_pkg::fsupc_state_e st_q, st_d;
  logic [31:0] fault_code_q;
  logic [31:0] enc_code;

  fsupc_fault_enc u_enc (
    .fault (prog_fault),
    .code  (enc_code)
  );

  always_comb begin
    st_d = st_q;
    case (st_q)
      fsupc_pkg::PS_STOPPED: begin
        if (on_rise) st_d = fsupc_pkg::PS_LOADING;
      end
      fsupc_pkg::PS_LOADING: begin
        if (!on_now) st_d = fsupc_pkg::PS_STOPPED;
        else if (prog_fault.valid) st_d = fsupc_pkg::PS_FAULTED;
        else if (prog_loaded) st_d = fsupc_pkg::PS_RUNNING;
      end
      fsupc_pkg::PS_RUNNING: begin
        if (prog_fault.valid) st_d = fsupc_pkg::PS_FAULTED;
        else if (!on_now || prog_stopped) st_d = fsupc_pkg::PS_STOPPED;
      end
      fsupc_pkg::PS_FAULTED: begin
        if (on_rise) st_d = fsupc_pkg::PS_LOADING;
      end
      default: st_d = fsupc_pkg::PS_STOPPED;
    endcase
  end

  wire fault_take = prog_fault.valid &&
                    (st_q == fsupc_pkg::PS_LOADING || st_q == fsupc_pkg::PS_RUNNING);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q         <= fsupc_pkg::PS_STOPPED;
      fault_code_q <= fsupc_pkg::FC_NONE;
    end else if (clk_en) begin
      st_q <= st_d;
      if (fault_take) fault_code_q <= enc_code;
      else if (on_rise) fault_code_q <= fsupc_pkg::FC_NONE;
    end
  end

  // reload is a one-cycle pulse: engine discards program and variables
  assign prog_reload = clk_en && on_rise;
  assign prog_enable = st_q == fsupc_pkg::PS_RUNNING;

  wire run_flag = st_q == fsupc_pkg::PS_RUNNING;
  wire err_flag = st_q == fsupc_pkg::PS_FAULTED;
  wire [31:0] state_word = {29'h0, err_flag, 1'b0, run_flag};

  // ==========================================================================
  // read mux; nothing here is mappable, host reads by index only
  wire [31:0] rd_mux = is_ctrl   ? ctrl_q :
                       is_state  ? state_word :
                       is_fault  ? fault_code_q :
                       is_count  ? {24'h0, fsupc_pkg::RST_ENTRY_COUNT} :
                       is_cap    ? cap_q :
                       is_active ? active_q : 32'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp <= '0;
    end else if (clk_en) begin
      rsp.valid <= acc;
      rsp.err   <= acc && (!hit || (req.wr && !is_ctrl));
      rsp.rdata <= req.rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================================================
  // checks
  a_err_clears_run: assert property (@(posedge clk_sys) disable iff (rst)
    err_flag |-> !run_flag) else $error("run and error both set");

  a_rise_reloads: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && on_rise && st_q == fsupc_pkg::PS_STOPPED |=> st_q == fsupc_pkg::PS_LOADING)
    else $error("rising on did not start load");

  a_no_run_direct: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == fsupc_pkg::PS_STOPPED |=> st_q != fsupc_pkg::PS_RUNNING)
    else $error("ran without reload");

  a_fault_holds_code: assert property (@(posedge clk_sys) disable iff (rst)
    err_flag && !on_rise && $stable(err_flag) |-> $stable(fault_code_q))
    else $error("fault code changed while faulted");

  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && wr_ok |=> ctrl_q == $past(req.wdata))
    else $error("control write lost");

  a_count_read: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && req.rd && is_count |=> rsp.valid && rsp.rdata == 32'h0000_0002)
    else $error("entry count wrong");

  a_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (active_q & 32'hFFF8_FF80) == 32'h0 && (cap_q & 32'hFFF8_FF80) == 32'h0)
    else $error("unused interface bit set");

  a_ro_write_err: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && req.wr && (is_cap || is_active || is_state) |=> rsp.err)
    else $error("write to read-only entry accepted");

  // a low enable must leave the sequencer and the stored code where they were
  a_enable_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    !clk_en |=> st_q == $past(st_q) && fault_code_q == $past(fault_code_q))
    else $error("state moved while clock enable low");

  a_status_bit1: assert property (@(posedge clk_sys) disable iff (rst)
    clk_en && req.rd && is_state |=> rsp.rdata[1] == 1'b0)
    else $error("reserved status bit set");

endmodule
`default_nettype wire

// file: fsupc_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// program engine stand-in: loads after a short delay, reports what it is told
module fsupc_engine_model #(
  parameter int LOAD_DLY = 5
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    prog_reload,
  input  wire fsupc_pkg::fsupc_fault_s fault_cmd,
  input  wire logic                    stop_cmd,
  output logic                         prog_loaded,
  output logic                         prog_stopped,
  output fsupc_pkg::fsupc_fault_s      prog_fault
);
  int cnt_q;

  // reload restarts the load countdown, variables cleared before run
  // real startup may take up to 200 ms; a short stand-in keeps runs brief
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cnt_q <= 0;
    else if (prog_reload) cnt_q <= LOAD_DLY;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end

  assign prog_loaded  = (cnt_q == 1);
  assign prog_stopped = stop_cmd;
  assign prog_fault   = fault_cmd;
endmodule
`default_nettype wire

// file: fsupc_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (g), (e)); end end
module fsupc_regs_tb_top;
  logic                    clk_sys;
  logic                    rst;
  logic                    clk_en;
  fsupc_pkg::fsupc_req_s   req;
  fsupc_pkg::fsupc_rsp_s   rsp;
  logic [31:0]             cap_mask_in;
  logic [31:0]             active_in;
  logic                    prog_reload;
  logic                    prog_enable;
  logic                    prog_loaded;
  logic                    prog_stopped;
  logic                    stop_cmd;
  fsupc_pkg::fsupc_fault_s prog_fault;
  fsupc_pkg::fsupc_fault_s fault_cmd;
  fsupc_pkg::fsupc_fault_s f;
  int                      errors;
  int                      comparisons;
  int                      reload_cnt;
  int                      rl;
  integer                  seed;

  fsupc_regs uut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .req(req), .rsp(rsp),
    .cap_mask_in(cap_mask_in), .active_in(active_in), .prog_reload(prog_reload),
    .prog_enable(prog_enable), .prog_loaded(prog_loaded), .prog_stopped(prog_stopped),
    .prog_fault(prog_fault));
  fsupc_engine_model u_engine (.clk_sys(clk_sys), .rst(rst), .prog_reload(prog_reload),
    .fault_cmd(fault_cmd), .stop_cmd(stop_cmd), .prog_loaded(prog_loaded),
    .prog_stopped(prog_stopped), .prog_fault(prog_fault));

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (prog_reload === 1'h1) reload_cnt++;

  // ==========================================================================
  // reference model and bus tasks
  function automatic logic [31:0] exp_code(fsupc_pkg::fsupc_fault_s x);
    case (x.kind)
      fsupc_pkg::FK_EXEC:   return {24'h0, x.code};
      fsupc_pkg::FK_FILE:   return 32'h0000_0100;
      fsupc_pkg::FK_MAP:    return {8'h10, x.index, x.subindex};
      fsupc_pkg::FK_ACCESS: return 32'h0000_1000 + x.code;
      default:              return 32'h0001_0002 + x.code;
    endcase
  endfunction

  task automatic acc(input logic r, input logic w, input logic [15:0] ix, input logic [7:0] sx,
                     input logic [31:0] wd, output fsupc_pkg::fsupc_rsp_s g);
    @(posedge clk_sys);
    req <= '{rd: r, wr: w, index: ix, subindex: sx, wdata: wd};
    @(posedge clk_sys);
    req.rd <= 1'h0;
    req.wr <= 1'h0;
    #1 g = rsp;
  endtask

  task automatic rd_chk(input logic [15:0] ix, input logic [7:0] sx, input logic [31:0] ex);
    fsupc_pkg::fsupc_rsp_s g;
    acc(1'h1, 1'h0, ix, sx, 32'h0, g);
    `CHK(g.valid, 1'h1)
    `CHK(g.err, 1'h0)
    `CHK(g.rdata, ex)
  endtask

  task automatic wr_chk(input logic [15:0] ix, input logic [7:0] sx, input logic [31:0] wd,
                        input logic ee);
    fsupc_pkg::fsupc_rsp_s g;
    acc(1'h0, 1'h1, ix, sx, wd, g);
    `CHK(g.valid, 1'h1)
    `CHK(g.err, ee)
  endtask

  // restart the program and wait, bounded, for it to run
  task automatic restart();
    int n;
    wr_chk(fsupc_pkg::IDX_PROG_CTRL, 8'h00, 32'h0, 1'h0);
    rl = reload_cnt;
    wr_chk(fsupc_pkg::IDX_PROG_CTRL, 8'h00, 32'h1, 1'h0);
    n = 0;
    while (prog_enable !== 1'h1 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(prog_enable, 1'h1)
    `CHK(reload_cnt - rl, 1)
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // ==========================================================================
  // scenarios
  initial begin
    seed = 94;
    clk_sys = 1'h0;
    rst = 1'h1;
    clk_en = 1'h1;
    req = '0;
    cap_mask_in = 32'h0;
    active_in = 32'h40;
    fault_cmd = '0;
    stop_cmd = 1'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    rd_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_COUNT, 32'h02);
    rd_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_CAP_MASK, 32'h0);
    rd_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_ACTIVE, 32'h40);
    rd_chk(fsupc_pkg::IDX_PROG_CTRL, 8'h00, 32'h0);
    rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h0);
    rd_chk(fsupc_pkg::IDX_PROG_FAULT, 8'h00, 32'h0);
    $display("test reset_values done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      cap_mask_in <= $random(seed);
      active_in <= $random(seed);
      @(posedge clk_sys);
      rd_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_CAP_MASK, cap_mask_in & 32'h0007_007F);
      rd_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_ACTIVE, active_in & 32'h0007_007F);
    end
    $display("test iface_words done");
    wr_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_COUNT, 32'h7, 1'h1);
    wr_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_ACTIVE, 32'hFFFF_FFFF, 1'h1);
    wr_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h5, 1'h1);
    wr_chk(fsupc_pkg::IDX_PROG_FAULT, 8'h00, 32'h1, 1'h1);
    wr_chk(16'h1234, 8'h00, 32'h1, 1'h1);
    rd_chk(fsupc_pkg::IDX_BUS_STATUS, fsupc_pkg::SUB_COUNT, 32'h02);
    rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h0);
    $display("test refusals done");
    // k/5 walks the exec, access and load kinds through their low, middle and high code; file and map kinds get random codes
    for (int k = 0; k < 15; k++) begin
      f.valid = 1'h1;
      f.kind = fsupc_pkg::fsupc_fault_kind_e'(k % 5);
      f.index = $random(seed);
      f.subindex = $random(seed);
      case (k % 5)
        0: f.code = 8'(1 + k / 5 * 3);
        3: f.code = 8'(k / 5);
        4: f.code = 8'(k / 5 * 7);
        default: f.code = $random(seed);
      endcase
      restart();
      rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h1);
      rd_chk(fsupc_pkg::IDX_PROG_FAULT, 8'h00, 32'h0);
      @(posedge clk_sys);
      fault_cmd <= f;
      @(posedge clk_sys);
      fault_cmd.valid <= 1'h0;
      rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h4);
      rd_chk(fsupc_pkg::IDX_PROG_FAULT, 8'h00, exp_code(f));
      `CHK(prog_enable, 1'h0)
    end
    $display("test fault_codes done");
    rl = reload_cnt;
    wr_chk(fsupc_pkg::IDX_PROG_CTRL, 8'h00, 32'h5, 1'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(reload_cnt - rl, 0)
    rd_chk(fsupc_pkg::IDX_PROG_CTRL, 8'h00, 32'h5);
    rd_chk(fsupc_pkg::IDX_PROG_FAULT, 8'h00, exp_code(f));
    restart();
    wr_chk(fsupc_pkg::IDX_PROG_CTRL, 8'h00, 32'h0, 1'h0);
    rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h0);
    restart();
    // a stop request while the enable is low must be ignored
    @(posedge clk_sys);
    clk_en <= 1'h0;
    stop_cmd <= 1'h1;
    repeat (2) @(posedge clk_sys);
    stop_cmd <= 1'h0;
    #1 `CHK(prog_enable, 1'h1)
    @(posedge clk_sys);
    clk_en <= 1'h1;
    rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h1);
    @(posedge clk_sys);
    stop_cmd <= 1'h1;
    @(posedge clk_sys);
    stop_cmd <= 1'h0;
    rd_chk(fsupc_pkg::IDX_PROG_STATE, 8'h00, 32'h0);
    rd_chk(fsupc_pkg::IDX_PROG_FAULT, 8'h00, 32'h0);
    $display("test on_off done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
